// File: shared_pin_function_select.sv
// Shared pin function select: software GPIO muxing, strap-fixed peripheral muxing
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module shared_pin_function_select #(
  parameter int unsigned HOST_PCI_W = 42,
  parameter int unsigned ATM_DED_W = 8,
  parameter int unsigned PCI_DED_W = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  // AXI4-Lite register port
  input wire logic [pin_mux_pkg::REG_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [pin_mux_pkg::REG_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Strap levels
  input wire logic atm_port_select_strap_i,
  input wire logic pci_select_strap_i,
  // GPIO pads
  input wire logic [pin_mux_pkg::GPIO_PINS-1:0] gpio_pad_in_i,
  output logic [pin_mux_pkg::GPIO_PINS-1:0] gpio_pad_out_o,
  output logic [pin_mux_pkg::GPIO_PINS-1:0] gpio_pad_oe_o,
  output logic serial2_external_clock_in_o,
  // PCI side of the upper GPIO pads
  input wire logic [pin_mux_pkg::PCI_GP_PINS-1:0] pci_gp_out_i,
  input wire logic [pin_mux_pkg::PCI_GP_PINS-1:0] pci_gp_oe_i,
  output logic [pin_mux_pkg::PCI_GP_PINS-1:0] pci_gp_in_o,
  // Serial port 1 / ATM address pads
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] sp1_pad_in_i,
  output logic [pin_mux_pkg::SP1_PINS-1:0] sp1_pad_out_o,
  output logic [pin_mux_pkg::SP1_PINS-1:0] sp1_pad_oe_o,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] serial1_out_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] serial1_oe_i,
  output logic [pin_mux_pkg::SP1_PINS-1:0] serial1_in_o,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] atm_addr_out_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] atm_addr_oe_i,
  output logic [pin_mux_pkg::SP1_PINS-1:0] atm_addr_in_o,
  // Host port / PCI shared pads
  input wire logic [HOST_PCI_W-1:0] shared_pad_in_i,
  output logic [HOST_PCI_W-1:0] shared_pad_out_o,
  output logic [HOST_PCI_W-1:0] shared_pad_oe_o,
  input wire logic [HOST_PCI_W-1:0] host_out_i,
  input wire logic [HOST_PCI_W-1:0] host_oe_i,
  output logic [HOST_PCI_W-1:0] host_in_o,
  input wire logic [HOST_PCI_W-1:0] pci_out_i,
  input wire logic [HOST_PCI_W-1:0] pci_oe_i,
  output logic [HOST_PCI_W-1:0] pci_in_o,
  // Dedicated ATM and PCI pads
  input wire logic [ATM_DED_W-1:0] atm_ded_pad_in_i,
  output logic [ATM_DED_W-1:0] atm_ded_pad_out_o,
  output logic [ATM_DED_W-1:0] atm_ded_pad_oe_o,
  input wire logic [ATM_DED_W-1:0] atm_ded_out_i,
  input wire logic [ATM_DED_W-1:0] atm_ded_oe_i,
  output logic [ATM_DED_W-1:0] atm_ded_in_o,
  input wire logic [PCI_DED_W-1:0] pci_ded_pad_in_i,
  output logic [PCI_DED_W-1:0] pci_ded_pad_out_o,
  output logic [PCI_DED_W-1:0] pci_ded_pad_oe_o,
  input wire logic [PCI_DED_W-1:0] pci_ded_out_i,
  input wire logic [PCI_DED_W-1:0] pci_ded_oe_i,
  output logic [PCI_DED_W-1:0] pci_ded_in_o,
  // Peripheral enables
  output logic atm_enable_o,
  output logic pci_enable_o
);
  import pin_mux_pkg::*;

  generate
    if (HOST_PCI_W < 1 || ATM_DED_W < 1 || PCI_DED_W < 1)
    begin : g_bad_width
      $error("shared_pin_function_select: pin group widths must be at least 1");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic aw_ready;
    logic w_ready;
    logic aw_full;
    logic w_full;
    logic [REG_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_ready;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [15:0] gpio_en;
    logic [15:0] gpio_dir;
    logic [15:0] gpio_out;
    logic strap_done;
    logic atm_sel;
    logic pci_sel;
    logic [GPIO_PINS-1:0] gp_out;
    logic [GPIO_PINS-1:0] gp_oe;
    logic serial2_clk;
    logic [PCI_GP_PINS-1:0] pci_gp_in;
    logic [SP1_PINS-1:0] sp1_out;
    logic [SP1_PINS-1:0] sp1_oe;
    logic [SP1_PINS-1:0] serial1_in;
    logic [SP1_PINS-1:0] atm_addr_in;
    logic [HOST_PCI_W-1:0] sh_out;
    logic [HOST_PCI_W-1:0] sh_oe;
    logic [HOST_PCI_W-1:0] host_in;
    logic [HOST_PCI_W-1:0] pci_in;
    logic [ATM_DED_W-1:0] atm_ded_out;
    logic [ATM_DED_W-1:0] atm_ded_oe;
    logic [ATM_DED_W-1:0] atm_ded_in;
    logic [PCI_DED_W-1:0] pci_ded_out;
    logic [PCI_DED_W-1:0] pci_ded_oe;
    logic [PCI_DED_W-1:0] pci_ded_in;
  } state_t;

  localparam state_t STATE_RST = '{
    aw_ready: 1'b1,
    w_ready: 1'b1,
    ar_ready: 1'b1,
    gpio_en: GPIO_ENABLE_RST,
    gpio_dir: GPIO_DIRECTION_RST,
    gpio_out: GPIO_OUTPUT_RST,
    default: '0
  };

  state_t s_ff;
  state_t nxt_s;
  logic quarter_clk;
  logic sixth_clk;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic reg_sel_t decode(input logic [REG_ADDR_W-1:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    unique case (w)
      OFS_GPIO_ENABLE: decode = SEL_ENABLE;
      OFS_GPIO_DIRECTION: decode = SEL_DIRECTION;
      OFS_GPIO_OUTPUT: decode = SEL_OUTPUT;
      OFS_GPIO_INPUT: decode = SEL_INPUT;
      OFS_STRAP_STATUS: decode = SEL_STRAP;
      default: decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0])
    begin
      merge16[7:0] = d[7:0];
    end
    if (strb[1])
    begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  // ****************************************************************
  // Fixed-rate clock sources
  // ****************************************************************
  clock_divider #(
    .DIV(QUARTER_DIV)
  ) u_quarter_div (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .clk_o(quarter_clk)
  );

  clock_divider #(
    .DIV(SIXTH_DIV)
  ) u_sixth_div (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .clk_o(sixth_clk)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    reg_sel_t wsel;
    reg_sel_t rsel;
    logic strap_atm;
    logic strap_pci;
    nxt_s = s_ff;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    strap_atm = s_ff.atm_sel;
    strap_pci = s_ff.pci_sel;

    // Straps are taken once on the first edge after reset release and then frozen
    if (!s_ff.strap_done)
    begin
      nxt_s.strap_done = 1'b1;
      nxt_s.atm_sel = atm_port_select_strap_i;
      nxt_s.pci_sel = pci_select_strap_i;
    end

    // Write channel: address and data are accepted independently
    if (s_axi_awvalid_i && s_ff.aw_ready)
    begin
      nxt_s.aw_full = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_ff.w_ready)
    begin
      nxt_s.w_full = 1'b1;
      nxt_s.w_data = s_axi_wdata_i;
      nxt_s.w_strb = s_axi_wstrb_i;
    end
    if (s_axi_bready_i && s_ff.b_valid)
    begin
      nxt_s.b_valid = 1'b0;
    end
    if (nxt_s.aw_full && nxt_s.w_full && !nxt_s.b_valid)
    begin
      wsel = decode(nxt_s.aw_addr);
      nxt_s.b_resp = RESP_OKAY;
      unique case (wsel)
        SEL_ENABLE: nxt_s.gpio_en = merge16(s_ff.gpio_en, nxt_s.w_data, nxt_s.w_strb);
        SEL_DIRECTION: nxt_s.gpio_dir = merge16(s_ff.gpio_dir, nxt_s.w_data, nxt_s.w_strb);
        SEL_OUTPUT: nxt_s.gpio_out = merge16(s_ff.gpio_out, nxt_s.w_data, nxt_s.w_strb);
        SEL_INPUT, SEL_STRAP, SEL_NONE: nxt_s.b_resp = RESP_SLVERR;
      endcase
      nxt_s.aw_full = 1'b0;
      nxt_s.w_full = 1'b0;
      nxt_s.b_valid = 1'b1;
    end
    // Holding ready low while a write waits gives one write in flight and no overrun
    nxt_s.aw_ready = !nxt_s.aw_full && !nxt_s.b_valid;
    nxt_s.w_ready = !nxt_s.w_full && !nxt_s.b_valid;

    // Read channel
    if (s_axi_rready_i && s_ff.r_valid)
    begin
      nxt_s.r_valid = 1'b0;
      nxt_s.ar_ready = 1'b1;
    end
    if (s_axi_arvalid_i && s_ff.ar_ready)
    begin
      rsel = decode(s_axi_araddr_i);
      nxt_s.r_valid = 1'b1;
      nxt_s.ar_ready = 1'b0;
      nxt_s.r_resp = RESP_OKAY;
      nxt_s.r_data = 32'h0000_0000;
      unique case (rsel)
        SEL_ENABLE: nxt_s.r_data[15:0] = s_ff.gpio_en;
        SEL_DIRECTION: nxt_s.r_data[15:0] = s_ff.gpio_dir;
        SEL_OUTPUT: nxt_s.r_data[15:0] = s_ff.gpio_out;
        SEL_INPUT: nxt_s.r_data[15:0] = gpio_pad_in_i;
        SEL_STRAP:
        begin
          nxt_s.r_data[STRAP_ATM_BIT] = s_ff.atm_sel;
          nxt_s.r_data[STRAP_PCI_BIT] = s_ff.pci_sel;
        end
        SEL_NONE: nxt_s.r_resp = RESP_SLVERR;
      endcase
    end

    // GPIO pads: plain GPIO path first, then the second functions override
    nxt_s.serial2_clk = 1'b0;
    for (int i = 0; i < GPIO_PINS; i++)
    begin
      nxt_s.gp_out[i] = s_ff.gpio_out[i];
      nxt_s.gp_oe[i] = s_ff.gpio_en[i] && s_ff.gpio_dir[i];
      if (i == PIN_QUARTER_CLK && !s_ff.gpio_en[i])
      begin
        nxt_s.gp_out[i] = quarter_clk;
        nxt_s.gp_oe[i] = 1'b1;
      end
      if (i == PIN_SIXTH_CLK && !s_ff.gpio_en[i])
      begin
        nxt_s.gp_out[i] = sixth_clk;
        nxt_s.gp_oe[i] = 1'b1;
      end
      if (i == PIN_SERIAL2_CLK && !s_ff.gpio_en[i])
      begin
        nxt_s.gp_oe[i] = 1'b0;
        nxt_s.serial2_clk = gpio_pad_in_i[i];
      end
      if (i >= PIN_PCI_LO && strap_pci)
      begin
        // PCI owns these pins whatever software has written
        nxt_s.gp_out[i] = pci_gp_out_i[i - PIN_PCI_LO];
        nxt_s.gp_oe[i] = pci_gp_oe_i[i - PIN_PCI_LO];
      end
    end
    nxt_s.pci_gp_in = strap_pci ? gpio_pad_in_i[GPIO_PINS-1:PIN_PCI_LO] : '0;

    // Serial port 1 versus ATM address pads
    if (strap_atm)
    begin
      nxt_s.sp1_out = atm_addr_out_i;
      nxt_s.sp1_oe = atm_addr_oe_i;
      nxt_s.atm_addr_in = sp1_pad_in_i;
      nxt_s.serial1_in = '0;
    end
    else
    begin
      nxt_s.sp1_out = serial1_out_i;
      nxt_s.sp1_oe = serial1_oe_i;
      nxt_s.serial1_in = sp1_pad_in_i;
      nxt_s.atm_addr_in = '0;
    end

    // Host port versus PCI shared pads
    if (strap_pci)
    begin
      nxt_s.sh_out = pci_out_i;
      nxt_s.sh_oe = pci_oe_i;
      nxt_s.pci_in = shared_pad_in_i;
      nxt_s.host_in = '0;
    end
    else
    begin
      nxt_s.sh_out = host_out_i;
      nxt_s.sh_oe = host_oe_i;
      nxt_s.host_in = shared_pad_in_i;
      nxt_s.pci_in = '0;
    end

    // Dedicated pads of a disabled peripheral float and feed it zeros
    nxt_s.atm_ded_out = strap_atm ? atm_ded_out_i : '0;
    nxt_s.atm_ded_oe = strap_atm ? atm_ded_oe_i : '0;
    nxt_s.atm_ded_in = strap_atm ? atm_ded_pad_in_i : '0;
    nxt_s.pci_ded_out = strap_pci ? pci_ded_out_i : '0;
    nxt_s.pci_ded_oe = strap_pci ? pci_ded_oe_i : '0;
    nxt_s.pci_ded_in = strap_pci ? pci_ded_pad_in_i : '0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_ff <= STATE_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign s_axi_awready_o = s_ff.aw_ready;
  assign s_axi_wready_o = s_ff.w_ready;
  assign s_axi_bresp_o = s_ff.b_resp;
  assign s_axi_bvalid_o = s_ff.b_valid;
  assign s_axi_arready_o = s_ff.ar_ready;
  assign s_axi_rdata_o = s_ff.r_data;
  assign s_axi_rresp_o = s_ff.r_resp;
  assign s_axi_rvalid_o = s_ff.r_valid;
  assign gpio_pad_out_o = s_ff.gp_out;
  assign gpio_pad_oe_o = s_ff.gp_oe;
  assign serial2_external_clock_in_o = s_ff.serial2_clk;
  assign pci_gp_in_o = s_ff.pci_gp_in;
  assign sp1_pad_out_o = s_ff.sp1_out;
  assign sp1_pad_oe_o = s_ff.sp1_oe;
  assign serial1_in_o = s_ff.serial1_in;
  assign atm_addr_in_o = s_ff.atm_addr_in;
  assign shared_pad_out_o = s_ff.sh_out;
  assign shared_pad_oe_o = s_ff.sh_oe;
  assign host_in_o = s_ff.host_in;
  assign pci_in_o = s_ff.pci_in;
  assign atm_ded_pad_out_o = s_ff.atm_ded_out;
  assign atm_ded_pad_oe_o = s_ff.atm_ded_oe;
  assign atm_ded_in_o = s_ff.atm_ded_in;
  assign pci_ded_pad_out_o = s_ff.pci_ded_out;
  assign pci_ded_pad_oe_o = s_ff.pci_ded_oe;
  assign pci_ded_in_o = s_ff.pci_ded_in;
  assign atm_enable_o = s_ff.atm_sel;
  assign pci_enable_o = s_ff.pci_sel;

endmodule

// File: pin_mux_pkg.sv
// Constants, register map and field layout for the shared pin function select block
package pin_mux_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned REG_ADDR_W = 12;
  localparam int unsigned GPIO_PINS = 16;
  localparam int unsigned SP1_PINS = 7;
  localparam int unsigned PCI_GP_PINS = 7;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_GPIO_ENABLE = 12'h000;
  localparam logic [11:0] OFS_GPIO_DIRECTION = 12'h004;
  localparam logic [11:0] OFS_GPIO_OUTPUT = 12'h008;
  localparam logic [11:0] OFS_GPIO_INPUT = 12'h00C;
  localparam logic [11:0] OFS_STRAP_STATUS = 12'h010;

  typedef enum logic [2:0] {
    SEL_ENABLE = 3'b000,
    SEL_DIRECTION = 3'b001,
    SEL_OUTPUT = 3'b010,
    SEL_INPUT = 3'b011,
    SEL_STRAP = 3'b100,
    SEL_NONE = 3'b111
  } reg_sel_t;

  // ****************************************************************
  // Reset values and fields
  // ****************************************************************
  localparam logic [15:0] GPIO_ENABLE_RST = 16'h0000;
  localparam logic [15:0] GPIO_DIRECTION_RST = 16'h0000;
  localparam logic [15:0] GPIO_OUTPUT_RST = 16'h0000;
  localparam int unsigned STRAP_ATM_BIT = 0;
  localparam int unsigned STRAP_PCI_BIT = 1;

  // Pins with a second function
  localparam int unsigned PIN_QUARTER_CLK = 1;
  localparam int unsigned PIN_SIXTH_CLK = 2;
  localparam int unsigned PIN_SERIAL2_CLK = 8;
  localparam int unsigned PIN_PCI_LO = 9;

  // ****************************************************************
  // Clock dividers and bus answers
  // ****************************************************************
  localparam int unsigned QUARTER_DIV = 4;
  localparam int unsigned SIXTH_DIV = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: clock_divider.sv
// Even-ratio clock divider with a registered output
`timescale 1ns/1ps

module clock_divider #(
  parameter int unsigned DIV = 4
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  output logic clk_o
);
  import pin_mux_pkg::*;

  localparam int unsigned HALF = DIV / 2;
  localparam int unsigned CNT_W = $clog2(HALF);

  // Odd ratios would give an uneven duty cycle, so they are refused
  generate
    if (DIV < 4 || (DIV % 2) != 0)
    begin : g_bad_div
      $error("clock_divider: DIV must be even and at least 4");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic clk;
  } div_state_t;

  div_state_t s_ff;
  div_state_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (s_ff.cnt == CNT_W'(HALF - 1))
    begin
      nxt_s.cnt = '0;
      nxt_s.clk = ~s_ff.clk;
    end
    else
    begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign clk_o = s_ff.clk;

endmodule

// File: pin_mux_checker.sv
// Port-level concurrent checks for the shared pin function select block
`timescale 1ns/1ps
module pin_mux_checker #(
  parameter int unsigned HOST_PCI_W = 42,
  parameter int unsigned ATM_DED_W = 8,
  parameter int unsigned PCI_DED_W = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic atm_enable_o,
  input wire logic pci_enable_o,
  input wire logic [pin_mux_pkg::GPIO_PINS-1:0] gpio_pad_oe_o,
  input wire logic [pin_mux_pkg::PCI_GP_PINS-1:0] pci_gp_oe_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] sp1_pad_out_o,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] sp1_pad_oe_o,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] serial1_out_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] serial1_oe_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] atm_addr_out_i,
  input wire logic [pin_mux_pkg::SP1_PINS-1:0] atm_addr_oe_i,
  input wire logic [HOST_PCI_W-1:0] shared_pad_oe_o,
  input wire logic [HOST_PCI_W-1:0] host_oe_i,
  input wire logic [HOST_PCI_W-1:0] shared_pad_out_o,
  input wire logic [HOST_PCI_W-1:0] host_out_i,
  input wire logic [HOST_PCI_W-1:0] pci_out_i,
  input wire logic [HOST_PCI_W-1:0] pci_oe_i,
  input wire logic [ATM_DED_W-1:0] atm_ded_pad_oe_o,
  input wire logic [ATM_DED_W-1:0] atm_ded_in_o,
  input wire logic [PCI_DED_W-1:0] pci_ded_pad_oe_o,
  input wire logic [PCI_DED_W-1:0] pci_ded_in_o
);
  import pin_mux_pkg::*;
  logic [1:0] cyc_ff;

  // ****************************************************************
  // Cycles since reset release; pad routing settles after two
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cyc_ff <= 2'h0;
    else if (cyc_ff != 2'h3)
      cyc_ff <= cyc_ff + 2'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_atm_on; cyc_ff == 2'h3 && atm_enable_o; endsequence
  sequence s_atm_off; cyc_ff == 2'h3 && !atm_enable_o; endsequence
  sequence s_pci_on; cyc_ff == 2'h3 && pci_enable_o; endsequence
  sequence s_pci_off; cyc_ff == 2'h3 && !pci_enable_o; endsequence

  strap_held_a:
    assert property (cyc_ff >= 2'h2 |-> $stable({atm_enable_o, pci_enable_o}))
    else $error("held strap changed");
  serial1_route_a:
    assert property (s_atm_off |=> {sp1_pad_out_o, sp1_pad_oe_o} ==
      $past({serial1_out_i, serial1_oe_i})) else $error("serial 1 pads misrouted");
  atm_route_a:
    assert property (s_atm_on |=> {sp1_pad_out_o, sp1_pad_oe_o} ==
      $past({atm_addr_out_i, atm_addr_oe_i})) else $error("atm address pads misrouted");
  host_route_a:
    assert property (s_pci_off |=> {shared_pad_out_o, shared_pad_oe_o} ==
      $past({host_out_i, host_oe_i})) else $error("host port pads misrouted");
  pci_route_a:
    assert property (s_pci_on |=> {shared_pad_out_o, shared_pad_oe_o} ==
      $past({pci_out_i, pci_oe_i})) else $error("pci pads misrouted");
  atm_tied_off_a:
    assert property (s_atm_off |-> atm_ded_pad_oe_o == '0 && atm_ded_in_o == '0)
    else $error("atm dedicated pads not tied off");
  pci_tied_off_a:
    assert property (s_pci_off |-> pci_ded_pad_oe_o == '0 && pci_ded_in_o == '0)
    else $error("pci dedicated pads not tied off");
  upper_pci_owns_a:
    assert property (s_pci_on |=> gpio_pad_oe_o[15:9] == $past(pci_gp_oe_i))
    else $error("upper pads not driven by pci");
  bresp_retire_a:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not retired");
  read_answer_a:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o [*1])
    else $error("read answer late");
endmodule

// File: board_model.sv
// Board model: strap resistors and the external device on the GPIO pads
`timescale 1ns/1ps
module board_model (
  input wire logic pull_atm_i,
  input wire logic pull_pci_i,
  input wire logic [pin_mux_pkg::GPIO_PINS-1:0] ext_level_i,
  input wire logic [pin_mux_pkg::GPIO_PINS-1:0] pad_out_i,
  input wire logic [pin_mux_pkg::GPIO_PINS-1:0] pad_oe_i,
  output logic atm_strap_o,
  output logic pci_strap_o,
  output logic [pin_mux_pkg::GPIO_PINS-1:0] pad_in_o
);
  import pin_mux_pkg::*;
  // Unfitted pull-up leaves the internal pull-down in charge
  assign atm_strap_o = pull_atm_i;
  assign pci_strap_o = pull_pci_i;
  // The external device drives only pads the block has released
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule

// File: test_shared_pin_function_select.sv
// Self-checking testbench for the shared pin function select block
`timescale 1ns/1ps
module test_shared_pin_function_select;
  import pin_mux_pkg::*;
  localparam int unsigned HOST_PCI_W = 42;
  localparam int unsigned ATM_DED_W = 8;
  localparam int unsigned PCI_DED_W = 8;
  localparam logic [15:0] EXT = 16'hA5C3;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [REG_ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic atm_port_select_strap_i, pci_select_strap_i, serial2_external_clock_in_o;
  logic atm_enable_o, pci_enable_o, pull_atm = 1'b0, pull_pci = 1'b0;
  logic [GPIO_PINS-1:0] gpio_pad_in_i, gpio_pad_out_o, gpio_pad_oe_o;
  logic [PCI_GP_PINS-1:0] pci_gp_out_i, pci_gp_oe_i, pci_gp_in_o;
  logic [SP1_PINS-1:0] sp1_pad_in_i, sp1_pad_out_o, sp1_pad_oe_o, serial1_out_i, serial1_oe_i;
  logic [SP1_PINS-1:0] serial1_in_o, atm_addr_out_i, atm_addr_oe_i, atm_addr_in_o;
  logic [HOST_PCI_W-1:0] shared_pad_in_i, shared_pad_out_o, shared_pad_oe_o, host_out_i;
  logic [HOST_PCI_W-1:0] host_oe_i, host_in_o, pci_out_i, pci_oe_i, pci_in_o;
  logic [ATM_DED_W-1:0] atm_ded_pad_in_i, atm_ded_pad_out_o, atm_ded_pad_oe_o;
  logic [ATM_DED_W-1:0] atm_ded_out_i, atm_ded_oe_i, atm_ded_in_o;
  logic [PCI_DED_W-1:0] pci_ded_pad_in_i, pci_ded_pad_out_o, pci_ded_pad_oe_o;
  logic [PCI_DED_W-1:0] pci_ded_out_i, pci_ded_oe_i, pci_ded_in_o;
  logic [63:0] tick_ff = 64'h0123456789ABCDEF;
  int mismatches = 0;
  int compares = 0;

  always #12.5 clock_i = ~clock_i;
  // Busy pattern on every peripheral side so misrouting cannot hide
  always @(posedge clock_i) tick_ff <= tick_ff * 64'h5851F42D4C957F2D + 64'h1;
  assign {serial1_out_i, serial1_oe_i, atm_addr_out_i, atm_addr_oe_i} = tick_ff[27:0];
  assign {pci_gp_out_i, pci_gp_oe_i, atm_ded_out_i, atm_ded_oe_i} = tick_ff[63:34];
  assign {pci_ded_out_i, pci_ded_oe_i, sp1_pad_in_i} = tick_ff[40:18];
  assign {atm_ded_pad_in_i, pci_ded_pad_in_i} = tick_ff[15:0];
  assign {host_out_i, host_oe_i} = {tick_ff[HOST_PCI_W-1:0], ~tick_ff[63:64-HOST_PCI_W]};
  assign {pci_out_i, pci_oe_i} = {host_oe_i, host_out_i};
  assign shared_pad_in_i = tick_ff[HOST_PCI_W+3:4];

  shared_pin_function_select #(.HOST_PCI_W(HOST_PCI_W), .ATM_DED_W(ATM_DED_W),
    .PCI_DED_W(PCI_DED_W)) u_dut (.*);
  board_model u_board (.pull_atm_i(pull_atm), .pull_pci_i(pull_pci), .ext_level_i(EXT),
    .pad_out_i(gpio_pad_out_o), .pad_oe_i(gpio_pad_oe_o), .atm_strap_o(atm_port_select_strap_i),
    .pci_strap_o(pci_select_strap_i), .pad_in_o(gpio_pad_in_i));

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic do_reset(input logic atm, input logic pci);
    pull_atm <= atm;
    pull_pci <= pci;
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask

  // One register access; waits on the handshake, never on a cycle count
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er, input logic [31:0] ed);
    int n;
    @(posedge clock_i);
    if (wr)
    begin
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
    end
    else
    begin
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
    end
    for (n = 0; n < 40; n++)
    begin
      @(posedge clock_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (wr ? s_axi_bvalid_o === 1'b1 : s_axi_rvalid_o === 1'b1) break;
    end
    s_axi_bready_i <= 1'b0;
    s_axi_rready_i <= 1'b0;
    if (n == 40)
    begin
      mismatches++;
      $display("wrong value bus answer expected 1 seen 0");
      end_of_test();
    end
    if (wr)
      check("write response", er, s_axi_bresp_o);
    else
    begin
      check("read response", er, s_axi_rresp_o);
      check("read data", ed, s_axi_rdata_o);
    end
  endtask

  task automatic reset_defaults();
    logic [11:0] s1, s2;
    int i;
    axi(1'b0, OFS_GPIO_ENABLE, 32'h0, RESP_OKAY, 32'h0);
    axi(1'b0, OFS_GPIO_DIRECTION, 32'h0, RESP_OKAY, 32'h0);
    for (i = 0; i < 12; i++)
    begin
      @(posedge clock_i);
      s1[i] = gpio_pad_out_o[1];
      s2[i] = gpio_pad_out_o[2];
    end
    for (i = 0; i < 6; i++)
    begin
      check("quarter clock", 1'b1, s1[i] ^ s1[i+2]);
      check("sixth clock", 1'b1, s2[i] ^ s2[i+3]);
    end
    check("clock pads driven", 2'h3, gpio_pad_oe_o[2:1]);
    check("serial 2 pad driver", 1'b0, gpio_pad_oe_o[8]);
    check("serial 2 clock in", EXT[8], serial2_external_clock_in_o);
  endtask

  task automatic gpio_use();
    axi(1'b1, OFS_GPIO_ENABLE, 32'h1026, RESP_OKAY, 32'h0);
    axi(1'b1, OFS_GPIO_DIRECTION, 32'h1022, RESP_OKAY, 32'h0);
    axi(1'b1, OFS_GPIO_OUTPUT, 32'h1020, RESP_OKAY, 32'h0);
    repeat (3) @(posedge clock_i);
    check("gpio drivers", 16'h1022, gpio_pad_oe_o);
    check("gpio levels", 16'h1020, gpio_pad_out_o & 16'h1022);
    check("pci upper inputs", 7'h00, pci_gp_in_o);
    axi(1'b0, OFS_GPIO_INPUT, 32'h0, RESP_OKAY, {16'h0, (EXT & ~16'h1022) | 16'h1020});
    axi(1'b1, OFS_STRAP_STATUS, 32'h3, RESP_SLVERR, 32'h0);
    axi(1'b0, 12'h0FC, 32'h0, RESP_SLVERR, 32'h0);
  endtask

  task automatic strap_run(input logic atm, input logic pci);
    do_reset(atm, pci);
    check("held atm strap", atm, atm_enable_o);
    check("held pci strap", pci, pci_enable_o);
    axi(1'b0, OFS_STRAP_STATUS, 32'h0, RESP_OKAY, {30'h0, pci, atm});
    pull_atm <= ~atm;
    pull_pci <= ~pci;
    axi(1'b1, OFS_GPIO_ENABLE, 32'hFE00, RESP_OKAY, 32'h0);
    axi(1'b1, OFS_GPIO_DIRECTION, 32'hFE00, RESP_OKAY, 32'h0);
    repeat (3) @(posedge clock_i);
    check("straps after change", {pci, atm}, {pci_enable_o, atm_enable_o});
    check("unused serial 1 side", 7'h00, atm ? serial1_in_o : atm_addr_in_o);
    check("unused host side", 42'h0, pci ? host_in_o : pci_in_o);
    if (!atm)
      check("atm pads off", 8'h00, atm_ded_pad_oe_o | atm_ded_in_o | atm_ded_pad_out_o);
    if (!pci)
    begin
      check("pci pads off", 8'h00, pci_ded_pad_oe_o | pci_ded_in_o | pci_ded_pad_out_o);
      check("upper gpio drivers", 7'h7F, gpio_pad_oe_o[15:9]);
    end
  endtask

  initial
  begin
    do_reset(1'b0, 1'b0);
    reset_defaults();
    gpio_use();
    strap_run(1'b1, 1'b0);
    strap_run(1'b0, 1'b1);
    end_of_test();
  end
endmodule

bind shared_pin_function_select pin_mux_checker #(.HOST_PCI_W(HOST_PCI_W),
  .ATM_DED_W(ATM_DED_W), .PCI_DED_W(PCI_DED_W)) u_chk (.*);
